// File: core/edge_filter.sv
// Digital filter for the external trigger pin, with rising-edge pulse out.
// Assumes the pin is already synchronous to clk; clock enable freezes it.
`timescale 1ns/10ps
module edge_filter #(
    parameter int FLT_W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Filter setting: consecutive samples needed minus one, 0 passes straight
    input wire logic [FLT_W-1:0] fltLen,
    // Pin and result
    input wire logic pinIn,
    output logic risePulse
);

    logic [FLT_W-1:0] agree_r;
    logic level_r;
    logic [FLT_W-1:0] agreeNxt;
    logic levelNxt;
    wire differs = (pinIn != level_r);
    wire settled = (agree_r >= fltLen);

    // ------
    // Filter: level changes only after fltLen+1 steady samples
    // ------
    always_comb begin
        agreeNxt = agree_r;
        levelNxt = level_r;
        if (!differs) begin
            agreeNxt = '0;
        end else if (settled) begin
            levelNxt = pinIn;
            agreeNxt = '0;
        end else begin
            agreeNxt = agree_r + 1'b1;
        end
    end

    // State registers; one pulse per filtered rising edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            agree_r <= '0;
            level_r <= 1'b0;
            risePulse <= 1'b0;
        end else if (clkEn) begin
            agree_r <= agreeNxt;
            level_r <= levelNxt;
            risePulse <= levelNxt & ~level_r; // R7
        end else begin
            risePulse <= 1'b0;
        end
    end

endmodule : edge_filter

// File: core/tb_time_base_pkg.sv
// Constants for the timer time base: register map, fields, reset values.
// Assumes a single 10 MHz module clock and a plain one-cycle register port.
//
// Function
// R1: Mode 000 clocks the prescaler from the module clock.
// R2: Enabled counter divides the source clock to the counter clock.
// R3: Modes 1,2,3,7 use the selected trigger; 4,5,6 the module clock.
// R4: Mode 7, select 4..6: count chosen edges of channel 0/1 pins.
// R5: Mode 7, select 0..3: count rises of internal triggers 0..3.
// R6: External trigger is source for mode-1 bit, or mode 7 select 7.
// R7: External trigger is filtered; one pulse per filtered rise.
// R8: 16-bit prescale value gives division factor value plus one.
// R9: Prescale writes take effect only at the next update.
// R10: Counter is 16-bit unsigned.
// R11: Up mode counts 0 to reload, wraps to 0 with overflow.
// R12: Up mode updates after repetition count plus one overflows.
// R13: Direction bit 0 counts up, 1 counts down.
// R14: Up mode software update clears counter and updates.
// R15: Down mode counts reload to 0, restarts at reload, underflows.
// R16: Down mode updates after repetition count plus one underflows.
// R17: Down mode software update loads reload value and updates.
// R18: Update disable suppresses all updates.
// R19: Each update copies repetition, reload and prescale shadows.
// R20: Center mode: overflow at reload-1 going up, underflow at 1.
// R21: Repetition counts down per overflow, underflow, or both.
package tb_time_base_pkg;

    // ------
    // Register offsets
    // ------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] SLAVE_OFS = 8'h04;
    localparam logic [7:0] EVENT_OFS = 8'h08;
    localparam logic [7:0] COUNT_OFS = 8'h0C;
    localparam logic [7:0] PRESC_OFS = 8'h10;
    localparam logic [7:0] RELOAD_OFS = 8'h14;
    localparam logic [7:0] REPEAT_OFS = 8'h18;
    localparam logic [7:0] STATUS_OFS = 8'h1C;

    // ------
    // Field positions
    // ------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_UPDATE_DISABLE_BIT = 1;
    localparam int CTRL_DIR_BIT = 4;
    localparam int CTRL_CENTER_BIT = 5;
    localparam int SLV_MODE_LSB = 0;
    localparam int SLV_TRG_LSB = 4;
    localparam int SLV_EXT1_BIT = 14;
    localparam int SLV_CHPOL_BIT = 15;
    localparam int SLV_FLT_LSB = 8;
    localparam int EVT_SWUPD_BIT = 0;

    // ------
    // Modes and trigger selections
    // ------
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_EXT0 = 3'h7;
    localparam logic [2:0] TRG_ETI = 3'h7;

    // ------
    // Reset values
    // ------
    localparam logic [15:0] RELOAD_RST = 16'hFFFF;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [3:0] FLT_RST = 4'h0;

endpackage : tb_time_base_pkg

// File: core/timer_time_base.sv
// Time base of a four-channel timer: clock select, prescaler, counter.
// Assumes synchronous inputs, one 10 MHz clock and the plain register port.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module timer_time_base #(
    parameter int CNT_W = 16,
    parameter int FLT_W = 4
) (
    // Clock, reset, freeze
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Clock sources
    input wire logic [3:0] internalTriggerInput,
    input wire logic channel0InputPin,
    input wire logic channel1InputPin,
    input wire logic externalTriggerInput,
    // Time base results
    output logic [CNT_W-1:0] countOut,
    output logic updateEvent,
    output logic overflowPulse,
    output logic underflowPulse
);

    initial begin
        if (CNT_W != 16) $error("counter width must be 16"); // R10
        if (FLT_W < 1 || FLT_W > 8) $error("filter width 1..8");
    end

    // ------
    // Software registers
    // ------
    logic counterEnable_r;
    logic updateDisable_r;
    logic countDown_r;
    logic centerMode_r;
    logic [2:0] slaveModeSelect_r;
    logic [2:0] triggerSourceSelect_r;
    logic externalClockMode1Enable_r;
    logic chFalling_r;
    logic [FLT_W-1:0] fltLen_r;
    logic [15:0] prescaleBuf_r;
    logic [15:0] reloadBuf_r;
    logic [15:0] repeatBuf_r;
    // Active copies and counters
    logic [15:0] prescaleAct_r;
    logic [15:0] reloadAct_r;
    logic [15:0] repeatLeft_r;
    logic [15:0] presCnt_r;
    logic [CNT_W-1:0] cnt_r;
    logic goingDown_r;
    logic [3:0] itiPrev_r;
    logic ch0Prev_r;
    logic ch1Prev_r;
    logic updFlag_r;

    // ------
    // Address decode
    // ------
    wire wrCtrl = regWr && (regAddr == tb_time_base_pkg::CTRL_OFS);
    wire wrSlave = regWr && (regAddr == tb_time_base_pkg::SLAVE_OFS);
    wire wrEvent = regWr && (regAddr == tb_time_base_pkg::EVENT_OFS);
    wire wrCount = regWr && (regAddr == tb_time_base_pkg::COUNT_OFS);
    wire wrPresc = regWr && (regAddr == tb_time_base_pkg::PRESC_OFS);
    wire wrReload = regWr && (regAddr == tb_time_base_pkg::RELOAD_OFS);
    wire wrRepeat = regWr && (regAddr == tb_time_base_pkg::REPEAT_OFS);
    wire swUpdate = wrEvent && regWdata[tb_time_base_pkg::EVT_SWUPD_BIT];

    // ------
    // Clock source selection
    // ------
    logic etiRise;
    edge_filter #(
        .FLT_W(FLT_W)
    ) u_eti_filter (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .fltLen(fltLen_r),
        .pinIn(externalTriggerInput),
        .risePulse(etiRise)
    );

    // Edges of the trigger inputs, seen against last sample
    wire [3:0] itiRise = internalTriggerInput & ~itiPrev_r;
    wire ch0Edge = chFalling_r ? (ch0Prev_r & ~channel0InputPin)
                               : (~ch0Prev_r & channel0InputPin);
    wire ch1Edge = chFalling_r ? (ch1Prev_r & ~channel1InputPin)
                               : (~ch1Prev_r & channel1InputPin);
    wire ext0Mode = (slaveModeSelect_r == tb_time_base_pkg::MODE_EXT0);
    wire trgMode = (slaveModeSelect_r == 3'h1) || (slaveModeSelect_r == 3'h2)
        || (slaveModeSelect_r == 3'h3) || ext0Mode; // R3
    logic trgTick;

    // Trigger selected source; 4 is either channel edge, 5 ch0, 6 ch1
    always_comb begin
        case (triggerSourceSelect_r)
            3'h0, 3'h1, 3'h2, 3'h3:
                trgTick = itiRise[triggerSourceSelect_r[1:0]]; // R5
            3'h4: trgTick = ch0Edge | ch1Edge; // R4
            3'h5: trgTick = ch0Edge; // R4
            3'h6: trgTick = ch1Edge; // R4
            default: trgTick = etiRise; // R6
        endcase
    end

    // Source tick: ext mode 1 wins; modes 4..6 and 0 use the module clock
    wire etiSel = externalClockMode1Enable_r
        || (ext0Mode && triggerSourceSelect_r == tb_time_base_pkg::TRG_ETI); // R6
    wire srcTick = etiSel ? etiRise : (trgMode ? trgTick : 1'b1); // R1 R3

    // ------
    // Prescaler and counter
    // ------
    wire presWrap = (presCnt_r == prescaleAct_r); // R8
    wire cntTick = counterEnable_r && srcTick && presWrap; // R2

    // Up: overflow at reload; center up: at reload-1 ahead of turn
    wire atTop = (cnt_r == reloadAct_r);
    wire upOvf = !centerMode_r && !countDown_r && atTop; // R11
    wire downUnf = !centerMode_r && countDown_r && (cnt_r == '0); // R15
    wire cenOvf = centerMode_r && !goingDown_r
        && (cnt_r == reloadAct_r - 16'h0001); // R20
    wire cenUnf = centerMode_r && goingDown_r && (cnt_r == 16'h0001); // R20
    wire ovf = cntTick && (upOvf || cenOvf);
    wire unf = cntTick && (downUnf || cenUnf);
    wire wrapEvt = ovf || unf; // R21
    wire repDone = (repeatLeft_r == '0);
    wire hwUpdate = wrapEvt && repDone && !updateDisable_r; // R12 R16 R18
    wire anyUpdate = hwUpdate || (swUpdate && !updateDisable_r); // R18

    logic [CNT_W-1:0] cntNxt;
    logic goingDownNxt;
    // Next count value and center-mode direction
    always_comb begin
        cntNxt = cnt_r;
        goingDownNxt = goingDown_r;
        if (swUpdate) begin
            cntNxt = countDown_r && !centerMode_r ? reloadAct_r : '0; // R14 R17
            goingDownNxt = 1'b0;
        end else if (wrCount) begin
            cntNxt = regWdata[CNT_W-1:0];
        end else if (cntTick) begin
            if (centerMode_r) begin
                if (!goingDown_r) begin
                    cntNxt = cnt_r + 16'h0001;
                    goingDownNxt = (cnt_r + 16'h0001 >= reloadAct_r);
                end else begin
                    cntNxt = cnt_r - 16'h0001;
                    goingDownNxt = (cnt_r > 16'h0001);
                end
            end else if (countDown_r) begin
                cntNxt = (cnt_r == '0) ? reloadAct_r : cnt_r - 16'h0001; // R15
            end else begin
                cntNxt = atTop ? '0 : cnt_r + 16'h0001; // R11
            end
        end
    end

    // Prescaler counter; restarts on an update so new factor starts clean
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presCnt_r <= tb_time_base_pkg::ZERO16;
        end else if (clkEn) begin
            if (anyUpdate || swUpdate) begin
                presCnt_r <= tb_time_base_pkg::ZERO16;
            end else if (counterEnable_r && srcTick) begin
                presCnt_r <= presWrap ? tb_time_base_pkg::ZERO16
                                      : presCnt_r + 16'h0001; // R2
            end
        end
    end

    // Counter, direction and edge history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            goingDown_r <= 1'b0;
            itiPrev_r <= 4'h0;
            ch0Prev_r <= 1'b0;
            ch1Prev_r <= 1'b0;
        end else if (clkEn) begin
            cnt_r <= cntNxt; // R10
            goingDown_r <= goingDownNxt;
            itiPrev_r <= internalTriggerInput;
            ch0Prev_r <= channel0InputPin;
            ch1Prev_r <= channel1InputPin;
        end
    end

    // Active copies loaded on update; repetition counts down per wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescaleAct_r <= tb_time_base_pkg::ZERO16;
            reloadAct_r <= tb_time_base_pkg::RELOAD_RST;
            repeatLeft_r <= tb_time_base_pkg::ZERO16;
        end else if (clkEn) begin
            if (anyUpdate) begin
                prescaleAct_r <= prescaleBuf_r; // R9 R19
                reloadAct_r <= reloadBuf_r; // R19
                repeatLeft_r <= repeatBuf_r; // R19
            end else if (wrapEvt && !repDone) begin
                repeatLeft_r <= repeatLeft_r - 16'h0001; // R21
            end
        end
    end

    // ------
    // Register writes and outputs
    // ------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counterEnable_r <= 1'b0;
            updateDisable_r <= 1'b0;
            countDown_r <= 1'b0;
            centerMode_r <= 1'b0;
            slaveModeSelect_r <= tb_time_base_pkg::MODE_OFF;
            triggerSourceSelect_r <= 3'h0;
            externalClockMode1Enable_r <= 1'b0;
            chFalling_r <= 1'b0;
            fltLen_r <= FLT_W'(tb_time_base_pkg::FLT_RST);
            prescaleBuf_r <= tb_time_base_pkg::ZERO16;
            reloadBuf_r <= tb_time_base_pkg::RELOAD_RST;
            repeatBuf_r <= tb_time_base_pkg::ZERO16;
        end else if (clkEn) begin
            if (wrCtrl) begin
                counterEnable_r <= regWdata[tb_time_base_pkg::CTRL_EN_BIT];
                updateDisable_r <= regWdata[tb_time_base_pkg::CTRL_UPDATE_DISABLE_BIT];
                countDown_r <= regWdata[tb_time_base_pkg::CTRL_DIR_BIT]; // R13
                centerMode_r <= regWdata[tb_time_base_pkg::CTRL_CENTER_BIT];
            end
            if (wrSlave) begin
                slaveModeSelect_r <=
                    regWdata[tb_time_base_pkg::SLV_MODE_LSB +: 3];
                triggerSourceSelect_r <=
                    regWdata[tb_time_base_pkg::SLV_TRG_LSB +: 3];
                externalClockMode1Enable_r <=
                    regWdata[tb_time_base_pkg::SLV_EXT1_BIT];
                chFalling_r <= regWdata[tb_time_base_pkg::SLV_CHPOL_BIT];
                fltLen_r <= regWdata[tb_time_base_pkg::SLV_FLT_LSB +: FLT_W];
            end
            if (wrPresc) begin
                prescaleBuf_r <= regWdata[15:0]; // R9
            end
            if (wrReload) begin
                reloadBuf_r <= regWdata[15:0];
            end
            if (wrRepeat) begin
                repeatBuf_r <= regWdata[15:0];
            end
        end
    end

    // Read mux: status shows center-mode direction and sticky update flag
    logic [31:0] rdMux;
    always_comb begin
        case (regAddr)
            tb_time_base_pkg::CTRL_OFS: rdMux = {26'h0, centerMode_r,
                countDown_r, 2'h0, updateDisable_r, counterEnable_r};
            tb_time_base_pkg::SLAVE_OFS: rdMux = {16'h0, chFalling_r,
                externalClockMode1Enable_r, 6'(fltLen_r), 1'b0,
                triggerSourceSelect_r, 1'b0, slaveModeSelect_r};
            tb_time_base_pkg::COUNT_OFS: rdMux = {16'h0, cnt_r};
            tb_time_base_pkg::PRESC_OFS: rdMux = {16'h0, prescaleBuf_r};
            tb_time_base_pkg::RELOAD_OFS: rdMux = {16'h0, reloadBuf_r};
            tb_time_base_pkg::REPEAT_OFS: rdMux = {16'h0, repeatBuf_r};
            tb_time_base_pkg::STATUS_OFS: rdMux = {30'h0, goingDown_r,
                updFlag_r};
            default: rdMux = 32'h0000_0000;
        endcase
    end
    wire rdStatus = regRd && (regAddr == tb_time_base_pkg::STATUS_OFS);

    // Outputs straight from flops; update flag set wins over read-clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 32'h0000_0000;
            countOut <= '0;
            updateEvent <= 1'b0;
            overflowPulse <= 1'b0;
            underflowPulse <= 1'b0;
            updFlag_r <= 1'b0;
        end else if (clkEn) begin
            regRdata <= regRd ? rdMux : 32'h0000_0000;
            countOut <= cntNxt;
            updateEvent <= anyUpdate; // R12 R16
            overflowPulse <= ovf;
            underflowPulse <= unf;
            updFlag_r <= anyUpdate || (updFlag_r && !rdStatus);
        end else begin
            updateEvent <= 1'b0;
            overflowPulse <= 1'b0;
            underflowPulse <= 1'b0;
        end
    end

endmodule : timer_time_base

// File: verification/time_base_checker_assertions.sv
// Checker for the timer time base, bound to its top module.
// Assumes one clock domain and the register map at 0x00..0x1C.
`timescale 1ns/10ps
module time_base_checker #(
    parameter int CNT_W = 16,
    parameter int FLT_W = 4
) (
    // Clock, reset, freeze
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    // Sources
    input wire logic [3:0] internalTriggerInput,
    input wire logic channel0InputPin,
    input wire logic channel1InputPin,
    input wire logic externalTriggerInput,
    // Results
    input wire logic [CNT_W-1:0] countOut,
    input wire logic updateEvent,
    input wire logic overflowPulse,
    input wire logic underflowPulse
);
    // ------
    // Mode tracking
    // ------
    logic dir_r, center_r, update_disable_r, ctrlWr, swuWr;
    // Mode is invisible at the ports, so follow control writes
    assign ctrlWr = regWr && clkEn && regAddr == 8'h00;
    assign swuWr = regWr && clkEn && regAddr == 8'h08 && regWdata[0];
    // Shadow of direction, center and update-disable bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_r <= 1'b0;
            center_r <= 1'b0;
            update_disable_r <= 1'b0;
        end else if (ctrlWr) begin
            dir_r <= regWdata[4];
            center_r <= regWdata[5];
            update_disable_r <= regWdata[1];
        end
    end
    // ------
    // Properties
    // ------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_swu_up;
        swuWr && !update_disable_r && !dir_r;
    endsequence
    sequence s_cleared;
        updateEvent && countOut == '0;
    endsequence
    property p_rd_zero; !$past(regRd) |-> regRdata == 32'h0; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("stray read data");
    property p_rd_cnt;
        regRd && clkEn && regAddr == 8'h0C |=>
            regRdata == 32'($past(countOut));
    endproperty
    a_rd_cnt: assert property (p_rd_cnt) else $error("count read");
    property p_ovf_up;
        overflowPulse && !dir_r && !center_r |-> countOut == '0;
    endproperty
    a_ovf_up: assert property (p_ovf_up) else $error("up wrap");
    property p_unf_dn;
        underflowPulse && dir_r && !center_r |-> $past(countOut) == '0;
    endproperty
    a_unf_dn: assert property (p_unf_dn) else $error("down wrap");
    property p_step;
        !$past(regWr) && !$past(regWr, 2) && !center_r &&
            $changed(countOut) |-> (dir_r ? ($past(countOut) == '0 ||
            countOut == $past(countOut) - 1'b1) : (countOut == '0 ||
            countOut == $past(countOut) + 1'b1));
    endproperty
    a_step: assert property (p_step) else $error("bad count step");
    property p_freeze; $past(!clkEn) |-> $stable(countOut); endproperty
    a_freeze: assert property (p_freeze) else $error("count moved");
    property p_update_disable; update_disable_r && $past(update_disable_r) |-> !updateEvent; endproperty
    a_update_disable: assert property (p_update_disable) else $error("update leaked");
    property p_swu_up; s_swu_up |-> ##[1:2] s_cleared; endproperty
    a_swu_up: assert property (p_swu_up) else $error("sw update up");
    property p_swu_dn;
        swuWr && !update_disable_r && dir_r |-> ##[1:2] updateEvent;
    endproperty
    a_swu_dn: assert property (p_swu_dn) else $error("sw update dn");
    property p_cause;
        updateEvent |-> overflowPulse || underflowPulse ||
            $past(swuWr) || $past(swuWr, 2);
    endproperty
    a_cause: assert property (p_cause) else $error("update no cause");
endmodule : time_base_checker

bind timer_time_base time_base_checker #(.CNT_W(CNT_W), .FLT_W(FLT_W))
    chk (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .internalTriggerInput(internalTriggerInput),
    .channel0InputPin(channel0InputPin),
    .channel1InputPin(channel1InputPin),
    .externalTriggerInput(externalTriggerInput), .countOut(countOut),
    .updateEvent(updateEvent), .overflowPulse(overflowPulse),
    .underflowPulse(underflowPulse));

// File: verification/timer_time_base_tb.sv
// Self-checking bench for the timer time base.
// Assumes design, checker and source model compiled first.
`timescale 1ns/10ps
module timer_time_base_tb;
    logic clk, rst_n, clkEn, regWr, regRd, go, busy, ch0, ch1, external_trigger_input;
    logic updateEvent, overflowPulse, underflowPulse;
    logic [7:0] regAddr, nEdges;
    logic [31:0] regWdata, regRdata, v;
    logic [3:0] trig, halfLen;
    logic [2:0] lineSel;
    logic [15:0] countOut;
    int nFail = 0;
    int checksDone = 0;
    int cyc = 0;
    int nOvf = 0;
    int r, p, p2, n, e, per, k;
    int updT[$];
    int ovfAt[$];
    int lineOf[13] = '{0, 1, 2, 3, 4, 4, 5, 7, 2, 4, 5, 7, 4};
    logic [31:0] cfg[13] = '{32'h07, 32'h17, 32'h27, 32'h37, 32'h47,
        32'h57, 32'h67, 32'h77, 32'h21, 32'h52, 32'h63, 32'h4000, 32'h8057};
    timer_time_base DUT (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .internalTriggerInput(trig),
        .channel0InputPin(ch0), .channel1InputPin(ch1),
        .externalTriggerInput(external_trigger_input), .countOut(countOut),
        .updateEvent(updateEvent), .overflowPulse(overflowPulse),
        .underflowPulse(underflowPulse));
    trigger_source_model src (.clk(clk), .rst_n(rst_n), .go(go),
        .lineSel(lineSel), .nEdges(nEdges), .halfLen(halfLen), .busy(busy),
        .trigOut(trig), .ch0Out(ch0), .ch1Out(ch1), .etiOut(external_trigger_input));
    // 10 MHz clock
    always #50 clk = ~clk;
    // Log of update instants and wraps
    always @(posedge clk) begin
        cyc++;
        if (overflowPulse === 1'b1 || underflowPulse === 1'b1) nOvf++;
        if (updateEvent === 1'b1) begin
            updT.push_back(cyc);
            ovfAt.push_back(nOvf);
        end
    end
    // ------
    // Shared tasks
    // ------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nFail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        d = regRdata;
    endtask : rd
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] d;
        rd(a, d);
        chk(d, x);
    endtask : rd_chk
    task automatic clear_log();
        @(negedge clk);
        updT.delete();
        ovfAt.delete();
        nOvf = 0;
    endtask : clear_log
    // Bounded wait for n logged updates; a stall ends the run
    task automatic wait_upd(input int cnt);
        for (k = 0; k < 600 && updT.size() < cnt; k++) @(negedge clk);
        if (updT.size() < cnt) begin
            chk(updT.size(), cnt);
            tally_and_finish();
        end
    endtask : wait_upd
    // ------
    // Main sequence
    // ------
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        clkEn = 1'b1;
        {regWr, regRd, go, regAddr, regWdata} = '0;
        {lineSel, nEdges, halfLen} = '0;
        v = $urandom(32'hC73BFFBC);
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wr(8'h20, 32'h5A);
        rd_chk(8'h20, 32'h0);
        rd_chk(8'h14, 32'hFFFF);
        rd_chk(8'h10, 32'h0);
        // Up count, repetition, prescale change
        r = 3 + $urandom_range(3);
        p = $urandom_range(2);
        n = $urandom_range(2);
        p2 = (p + 1) % 3;
        per = (r + 1) * (n + 1);
        wr(8'h14, r);
        wr(8'h10, p);
        wr(8'h18, n);
        wr(8'h08, 32'h1);
        wr(8'h00, 32'h1);
        clear_log();
        wait_upd(1);
        wr(8'h10, p2);
        wait_upd(3);
        chk(updT[1] - updT[0], per * (p + 1));
        chk(updT[2] - updT[1], per * (p2 + 1));
        chk(ovfAt[2] - ovfAt[0], 2 * (n + 1));
        // Down count, software update loads the reload value
        wr(8'h00, 32'h10);
        wr(8'h08, 32'h1);
        rd_chk(8'h0C, r);
        wr(8'h00, 32'h11);
        clear_log();
        wait_upd(2);
        chk(updT[1] - updT[0], per * (p2 + 1));
        chk(ovfAt[1] - ovfAt[0], n + 1);
        // Stopped counter holds; software update clears it in up mode
        wr(8'h00, 32'h0);
        wr(8'h0C, 32'h5);
        rd_chk(8'h0C, 32'h5);
        clear_log();
        wr(8'h08, 32'h1);
        rd_chk(8'h0C, 32'h0);
        chk(updT.size(), 32'h1);
        // Update disable with a freeze in the middle
        wr(8'h00, 32'h3);
        clear_log();
        repeat (20) @(posedge clk);
        clkEn <= 1'b0;
        repeat (20) @(posedge clk);
        clkEn <= 1'b1;
        repeat (150) @(posedge clk);
        wr(8'h08, 32'h1);
        repeat (3) @(posedge clk);
        chk(updT.size(), 32'h0);
        chk(32'(nOvf > 0), 32'h1);
        // Modes 4..6 keep the module clock
        wr(8'h00, 32'h0);
        wr(8'h14, 32'hFFFF);
        wr(8'h10, 32'h0);
        wr(8'h18, 32'h0);
        wr(8'h08, 32'h1);
        for (int m = 4; m < 7; m++) begin
            wr(8'h04, m | 32'h70);
            wr(8'h0C, 32'h0);
            wr(8'h00, 32'h1);
            repeat (40) @(posedge clk);
            wr(8'h00, 32'h0);
            rd(8'h0C, v);
            chk(32'(v >= 40 && v <= 44), 32'h1);
        end
        // Each external source counts its edges
        for (int i = 0; i < 13; i++) begin
            e = 1 + $urandom_range(4);
            wr(8'h04, cfg[i] | ($urandom_range(3) << 8));
            wr(8'h0C, 32'h0);
            wr(8'h00, 32'h1);
            lineSel <= 3'(lineOf[i]);
            nEdges <= 8'(e);
            halfLen <= 4'(4 + $urandom_range(4));
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            @(negedge clk);
            for (k = 0; k < 200 && busy; k++) @(negedge clk);
            chk(32'(busy), 32'h0);
            if (busy) tally_and_finish();
            repeat (12) @(posedge clk);
            rd_chk(8'h0C, e);
            wr(8'h00, 32'h0);
        end
        tally_and_finish();
    end
endmodule : timer_time_base_tb

// File: verification/trigger_source_model.sv
// Far side of the timer: peer triggers, channel pins, trigger pin.
// Assumes the bench pulses go once and then waits while busy is high.
`timescale 1ns/10ps
module trigger_source_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Burst request
    input wire logic go,
    input wire logic [2:0] lineSel,
    input wire logic [7:0] nEdges,
    input wire logic [3:0] halfLen,
    output logic busy,
    // Lines towards the timer
    output logic [3:0] trigOut,
    output logic ch0Out,
    output logic ch1Out,
    output logic etiOut
);
    logic [7:0] left_r;
    logic [3:0] phase_r;
    logic level_r;
    // Square burst; ends low so the next burst opens with a rise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_r <= 8'h00;
            phase_r <= 4'h0;
            level_r <= 1'b0;
        end else if (go) begin
            left_r <= nEdges;
            phase_r <= 4'h0;
            level_r <= 1'b0;
        end else if (left_r != 8'h00) begin
            phase_r <= (phase_r == halfLen) ? 4'h0 : phase_r + 4'h1;
            if (phase_r == halfLen) begin
                level_r <= !level_r;
                left_r <= level_r ? left_r - 8'h01 : left_r;
            end
        end
    end
    // Only the chosen line moves, the rest rest low
    assign busy = left_r != 8'h00;
    assign trigOut = lineSel < 3'h4 ? 4'(level_r) << lineSel[1:0] : 4'h0;
    assign ch0Out = level_r && lineSel == 3'h4;
    assign ch1Out = level_r && lineSel == 3'h5;
    assign etiOut = level_r && lineSel == 3'h7;
endmodule : trigger_source_model
